// ### rtl/mbrtu_pkg.sv
// Constants and carrier types for the Modbus-RTU slave frame handler.
package mbrtu_pkg;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam logic [4:0] SILENT_BITS = 5'h18;
   // ***************************************************************
   // Addressing, sizes and limits
   // ***************************************************************
   localparam logic [5:0] NODE_MIN = 6'h01;
   localparam logic [5:0] NODE_MAX = 6'h20;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam int BUF_DEPTH = 32;
   localparam int NUM_COILS = 32;
   localparam int NUM_REGS = 16;
   localparam logic [15:0] MAX_COILS = 16'h0020;
   localparam logic [15:0] MAX_REGS = 16'h0004;
   localparam logic [15:0] REG_MAX = 16'h7FFF;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [5:0] LEN_MIN = 6'h04;
   localparam logic [5:0] LEN_FIXED = 6'h08;
   localparam logic [7:0] LEN_MULTI_HDR = 8'h09;
   localparam logic [5:0] LEN_CRC = 6'h02;
   localparam logic [5:0] LEN_HDR = 6'h03;
   // ***************************************************************
   // Check code
   // ***************************************************************
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   // ***************************************************************
   // Function and exception codes
   // ***************************************************************
   localparam logic [7:0] FC_RD_COILS = 8'h01;
   localparam logic [7:0] FC_RD_REGS = 8'h03;
   localparam logic [7:0] FC_WR_COIL = 8'h05;
   localparam logic [7:0] FC_WR_REG = 8'h06;
   localparam logic [7:0] FC_LOOPBACK = 8'h08;
   localparam logic [7:0] FC_WR_COILS = 8'h0F;
   localparam logic [7:0] FC_WR_REGS = 8'h10;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EX_NONE = 8'h00;
   localparam logic [7:0] EX_FUNC = 8'h01;
   localparam logic [7:0] EX_ADDR = 8'h02;
   localparam logic [7:0] EX_DATA = 8'h03;
   localparam logic [7:0] EX_RANGE = 8'h21;
   localparam logic [7:0] EX_LOCK = 8'h22;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {RK_ECHO, RK_READ, RK_EXC} mbrtu_kind_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mbrtu_byte_t;
endpackage

// ### rtl/mbrtu_slave.sv
// Modbus-RTU slave frame handler: framing, checking, execution and response.
`timescale 1ns/1ps
module mbrtu_slave #(
   parameter int P_CYC_PER_MS = mbrtu_pkg::CYC_PER_MS
) (
   // Clock and reset.
   input wire i_core_clk,
   input wire i_rst,
   // Receive stream and bit-time enable from the serial port.
   input wire i_bit_tick,
   input mbrtu_pkg::mbrtu_byte_t i_rx,
   // Transmit stream to the serial port.
   input wire i_tx_ready,
   output mbrtu_pkg::mbrtu_byte_t o_tx,
   // Settings.
   input wire [5:0] i_node_address_setting,
   input wire [9:0] i_response_wait_time,
   input wire i_write_lock,
   // Data objects.
   output logic [31:0] o_coils,
   output logic [15:0][15:0] o_hold_regs
);
   // ***************************************************************
   // Declarations
   // ***************************************************************
   typedef enum {ST_IDLE, ST_RECV, ST_DROP, ST_EVAL, ST_WAIT, ST_SEND} mbrtu_state_t;
   mbrtu_state_t state_r;
   logic [7:0] buf_r [mbrtu_pkg::BUF_DEPTH];
   logic [5:0] len_r;
   logic ovf_r;
   logic [15:0] crc_r;
   logic [4:0] gap_r;
   mbrtu_pkg::mbrtu_kind_t kind_r;
   logic [7:0] exc_r;
   logic [5:0] tx_len_r;
   logic [5:0] pos_r;
   logic [15:0] tx_crc_r;
   logic [15:0] ms_cnt_r;
   logic [9:0] wait_cnt_r;
   logic [31:0] coils_r;
   logic [15:0][15:0] regs_r;
   mbrtu_pkg::mbrtu_byte_t tx_r;

   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ mbrtu_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ***************************************************************
   // Query decoding
   // ***************************************************************
   wire rx_fire = i_rx.valid;
   wire tx_fire = tx_r.valid & i_tx_ready;
   wire gap_done = gap_r == mbrtu_pkg::SILENT_BITS;
   wire [7:0] func = buf_r[1];
   wire [15:0] start = {buf_r[2], buf_r[3]};
   wire [15:0] cnt = {buf_r[4], buf_r[5]};
   wire [7:0] bcnt = buf_r[6];
   wire node_ok = i_node_address_setting >= mbrtu_pkg::NODE_MIN &&
                  i_node_address_setting <= mbrtu_pkg::NODE_MAX;
   wire addr_me = node_ok && buf_r[0] == {2'b00, i_node_address_setting};
   wire addr_bc = buf_r[0] == mbrtu_pkg::ADDR_BCAST;
   wire crc_ok = crc_r == 16'h0000 && len_r >= mbrtu_pkg::LEN_MIN && !ovf_r;
   wire is_rd = func == mbrtu_pkg::FC_RD_COILS || func == mbrtu_pkg::FC_RD_REGS;
   wire is_ws = func == mbrtu_pkg::FC_WR_COIL || func == mbrtu_pkg::FC_WR_REG;
   wire is_wm = func == mbrtu_pkg::FC_WR_COILS || func == mbrtu_pkg::FC_WR_REGS;
   wire is_lb = func == mbrtu_pkg::FC_LOOPBACK;
   wire is_coil = func == mbrtu_pkg::FC_RD_COILS || func == mbrtu_pkg::FC_WR_COIL ||
                  func == mbrtu_pkg::FC_WR_COILS;
   wire is_supp = is_rd | is_ws | is_wm | is_lb;
   wire len_ok = (is_rd | is_ws) ? len_r == mbrtu_pkg::LEN_FIXED :
                 is_wm ? {2'b00, len_r} == mbrtu_pkg::LEN_MULTI_HDR + bcnt : 1'b1;
   wire [7:0] rd_bytes = is_coil ? 8'((cnt + 16'h0007) >> 3) : 8'(cnt << 1);
   wire [15:0] lim = is_coil ? mbrtu_pkg::MAX_COILS : mbrtu_pkg::MAX_REGS;
   wire [15:0] cnt_eff = is_ws ? 16'h0001 : cnt;
   wire bad_cnt = ((is_rd | is_wm) && (cnt == 16'h0000 || cnt > lim)) ||
                  (is_wm && bcnt != rd_bytes);
   wire bad_val = func == mbrtu_pkg::FC_WR_COIL && cnt != mbrtu_pkg::COIL_ON &&
                  cnt != mbrtu_pkg::COIL_OFF;
   wire bad_addr = !is_lb && (17'(start) + 17'(cnt_eff)) >
                   (is_coil ? 17'(mbrtu_pkg::NUM_COILS) : 17'(mbrtu_pkg::NUM_REGS));
   logic reg_over;
   always_comb begin
      reg_over = func == mbrtu_pkg::FC_WR_REG && cnt > mbrtu_pkg::REG_MAX;
      for (int k = 0; k < 4; k++) begin
         if (func == mbrtu_pkg::FC_WR_REGS && 16'(k) < cnt &&
             {buf_r[7 + 2 * k], buf_r[8 + 2 * k]} > mbrtu_pkg::REG_MAX) begin
            reg_over = 1'b1;
         end
      end
   end
   wire is_write = is_ws | is_wm;
   wire [7:0] exc_code = !is_supp ? mbrtu_pkg::EX_FUNC :
                         (bad_cnt | bad_val) ? mbrtu_pkg::EX_DATA :
                         bad_addr ? mbrtu_pkg::EX_ADDR :
                         reg_over ? mbrtu_pkg::EX_RANGE :
                         (is_write & i_write_lock) ? mbrtu_pkg::EX_LOCK : mbrtu_pkg::EX_NONE;
   wire has_exc = exc_code != mbrtu_pkg::EX_NONE;
   wire accept = crc_ok && len_ok && (addr_me || addr_bc);
   wire do_exec = state_r == ST_EVAL && !rx_fire && accept && !has_exc && is_write;
   wire respond = accept && addr_me;

   // ***************************************************************
   // Response byte selection
   // ***************************************************************
   wire [31:0] rd_coils = 32'((64'(coils_r) >> start[4:0]) & ((64'h1 << cnt[5:0]) - 64'h1));
   wire [5:0] dk = pos_r - mbrtu_pkg::LEN_HDR;
   wire [3:0] rk = start[3:0] + 4'(dk[2:1]);
   wire [7:0] rd_byte = is_coil ? rd_coils[8 * dk[1:0] +: 8] :
                        dk[0] ? regs_r[rk][7:0] : regs_r[rk][15:8];
   wire [7:0] rd_resp = pos_r == 6'h00 ? buf_r[0] : pos_r == 6'h01 ? func :
                        pos_r == 6'h02 ? rd_bytes : rd_byte;
   wire [7:0] ex_resp = pos_r == 6'h00 ? buf_r[0] :
                        pos_r == 6'h01 ? (func | mbrtu_pkg::EXC_FLAG) : exc_r;
   wire [7:0] pay = kind_r == mbrtu_pkg::RK_ECHO ? buf_r[pos_r[4:0]] :
                    kind_r == mbrtu_pkg::RK_READ ? rd_resp : ex_resp;
   wire [7:0] tx_next = pos_r < tx_len_r ? pay :
                        pos_r == tx_len_r ? tx_crc_r[7:0] : tx_crc_r[15:8];
   wire tx_load = state_r == ST_SEND && (!tx_r.valid || i_tx_ready);
   wire tx_last = pos_r == tx_len_r + mbrtu_pkg::LEN_CRC;
   wire [5:0] shown_pos = pos_r - 6'h01;
   wire [63:0] cmask = ((64'h1 << cnt_eff[5:0]) - 64'h1) << start[4:0];
   wire [31:0] wdat = is_ws ? {31'h0, cnt == mbrtu_pkg::COIL_ON} :
                      {buf_r[10], buf_r[9], buf_r[8], buf_r[7]};
   wire [31:0] cdat = 32'(64'(wdat) << start[4:0]);

   // ***************************************************************
   // Silence timing and frame capture
   // ***************************************************************
   // The gap is cleared by traffic in either direction, so a query that follows
   // our own answer too closely is dropped like any other short gap.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_r <= 5'h00;
      end else if (rx_fire || tx_fire) begin
         gap_r <= 5'h00;
      end else if (i_bit_tick && !gap_done) begin
         gap_r <= gap_r + 5'h01;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (rx_fire && (state_r == ST_IDLE || state_r == ST_RECV) &&
          len_r < 6'(mbrtu_pkg::BUF_DEPTH)) begin
         buf_r[state_r == ST_IDLE ? 5'h00 : len_r[4:0]] <= i_rx.data;
      end
   end

   // ***************************************************************
   // Data objects
   // ***************************************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         coils_r <= 32'h0;
         regs_r <= '0;
      end else if (do_exec && is_coil) begin
         coils_r <= (coils_r & ~cmask[31:0]) | (cdat & cmask[31:0]);
      end else if (do_exec) begin
         for (int k = 0; k < 4; k++) begin
            if (16'(k) < cnt_eff) begin
               regs_r[start[3:0] + 4'(k)] <= is_ws ? cnt : {buf_r[7 + 2 * k], buf_r[8 + 2 * k]};
            end
         end
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         len_r <= 6'h00;
         ovf_r <= 1'b0;
         crc_r <= mbrtu_pkg::CRC_INIT;
         kind_r <= mbrtu_pkg::RK_ECHO;
         exc_r <= mbrtu_pkg::EX_NONE;
         tx_len_r <= 6'h00;
         pos_r <= 6'h00;
         tx_crc_r <= mbrtu_pkg::CRC_INIT;
         ms_cnt_r <= 16'h0000;
         wait_cnt_r <= 10'h000;
         tx_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (rx_fire && gap_done) begin
                  state_r <= ST_RECV;
                  len_r <= 6'h01;
                  ovf_r <= 1'b0;
                  crc_r <= crc_upd(mbrtu_pkg::CRC_INIT, i_rx.data);
               end else if (rx_fire) begin
                  state_r <= ST_DROP;
               end
            end
            ST_RECV: begin
               if (rx_fire) begin
                  crc_r <= crc_upd(crc_r, i_rx.data);
                  if (len_r < 6'(mbrtu_pkg::BUF_DEPTH)) begin
                     len_r <= len_r + 6'h01;
                  end else begin
                     ovf_r <= 1'b1;
                  end
               end else if (gap_done) begin
                  state_r <= ST_EVAL;
               end
            end
            ST_DROP: begin
               if (!rx_fire && gap_done) begin
                  state_r <= ST_IDLE;
               end
            end
            ST_EVAL: begin
               if (rx_fire) begin
                  state_r <= ST_DROP;
               end else if (respond) begin
                  state_r <= ST_WAIT;
                  exc_r <= exc_code;
                  wait_cnt_r <= i_response_wait_time;
                  ms_cnt_r <= 16'h0000;
                  if (has_exc) begin
                     kind_r <= mbrtu_pkg::RK_EXC;
                     tx_len_r <= mbrtu_pkg::LEN_HDR;
                  end else if (is_rd) begin
                     kind_r <= mbrtu_pkg::RK_READ;
                     tx_len_r <= mbrtu_pkg::LEN_HDR + rd_bytes[5:0];
                  end else begin
                     kind_r <= mbrtu_pkg::RK_ECHO;
                     tx_len_r <= len_r - mbrtu_pkg::LEN_CRC;
                  end
               end else begin
                  state_r <= ST_IDLE;
               end
            end
            ST_WAIT: begin
               // Traffic here means the master broke the silence; the answer is abandoned.
               if (rx_fire) begin
                  state_r <= ST_DROP;
               end else if (wait_cnt_r == 10'h000) begin
                  state_r <= ST_SEND;
                  pos_r <= 6'h00;
                  tx_crc_r <= mbrtu_pkg::CRC_INIT;
               end else if (ms_cnt_r == 16'(P_CYC_PER_MS - 1)) begin
                  ms_cnt_r <= 16'h0000;
                  wait_cnt_r <= wait_cnt_r - 10'h001;
               end else begin
                  ms_cnt_r <= ms_cnt_r + 16'h0001;
               end
            end
            ST_SEND: begin
               if (tx_load && tx_last) begin
                  tx_r.valid <= 1'b0;
                  state_r <= ST_IDLE;
               end else if (tx_load) begin
                  tx_r <= '{valid: 1'b1, data: tx_next};
                  pos_r <= pos_r + 6'h01;
                  if (pos_r < tx_len_r) begin
                     tx_crc_r <= crc_upd(tx_crc_r, pay);
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign o_tx = tx_r;
   assign o_coils = coils_r;
   assign o_hold_regs = regs_r;

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_ADDR_FILTER: assert property (
      state_r == ST_EVAL && !rx_fire && !addr_me && !addr_bc |=> state_r == ST_IDLE)
      else $error("Foreign address was not dropped.");
   AST_BCAST_SILENT: assert property (
      state_r == ST_EVAL && addr_bc |=> state_r != ST_WAIT)
      else $error("Broadcast query led to a response.");
   AST_BAD_CRC: assert property (
      state_r == ST_EVAL && !crc_ok |=> state_r != ST_WAIT && $stable(coils_r) && $stable(regs_r))
      else $error("Corrupted query was acted upon.");
   AST_SHORT_GAP: assert property (
      state_r == ST_IDLE && rx_fire && !gap_done |=> state_r == ST_DROP)
      else $error("Query after short silence was taken.");
   AST_FRAME_END: assert property (
      state_r == ST_RECV && !rx_fire && gap_done |=> state_r == ST_EVAL)
      else $error("Idle line did not end the frame.");
   AST_ZERO_WAIT: assert property (
      state_r == ST_EVAL && !rx_fire && respond && i_response_wait_time == 10'h000
      |=> state_r == ST_WAIT ##1 state_r == ST_SEND ##1 tx_r.valid)
      else $error("Response did not start after the silence.");
   AST_ECHO: assert property (
      tx_r.valid && kind_r == mbrtu_pkg::RK_ECHO && shown_pos < tx_len_r
      |-> tx_r.data == buf_r[shown_pos[4:0]])
      else $error("Echo byte differs from the query.");
   AST_READ_HDR: assert property (
      tx_r.valid && kind_r == mbrtu_pkg::RK_READ && shown_pos == 6'h01 |-> tx_r.data == func)
      else $error("Read response has wrong function code.");
   AST_EXC_FUNC: assert property (
      tx_r.valid && kind_r == mbrtu_pkg::RK_EXC && shown_pos == 6'h01
      |-> tx_r.data == (func | mbrtu_pkg::EXC_FLAG))
      else $error("Exception function code lacks the flag.");
   AST_EXC_NOEXEC: assert property (
      state_r == ST_EVAL && has_exc |=> $stable(coils_r) && $stable(regs_r))
      else $error("Erroneous query was executed.");
   AST_TX_ONLY_SEND: assert property (
      $rose(tx_r.valid) |-> $past(state_r) == ST_SEND)
      else $error("Transmission without a query.");

   COV_READ: cover property (tx_fire && kind_r == mbrtu_pkg::RK_READ && tx_last);
   COV_ECHO: cover property (tx_fire && kind_r == mbrtu_pkg::RK_ECHO && tx_last);
   COV_EXC: cover property (tx_fire && kind_r == mbrtu_pkg::RK_EXC && tx_last);
   COV_BCAST_WRITE: cover property (do_exec && addr_bc);
endmodule

// ### test/mbrtu_master_model.sv
// Bus master model: bit-time ticks, query bytes out, response bytes gathered.
`timescale 1ns/1ps
module mbrtu_master_model #(
   parameter int P_TICK = 4
) (
   // Clock.
   input wire i_core_clk,
   // Stall request from the bench.
   input wire i_slow,
   // Response stream from the handler.
   input mbrtu_pkg::mbrtu_byte_t i_tx,
   // Serial side towards the handler.
   output logic o_bit_tick,
   output mbrtu_pkg::mbrtu_byte_t o_rx,
   output logic o_tx_ready
);
   // ***************************************************************
   // Line timing and capture
   // ***************************************************************
   logic [7:0] rsp[$];
   int cyc = 0;
   int last_rx = 0;
   int first_tx = -1;
   initial begin
      o_bit_tick = 1'b0;
      o_rx = 9'h000;
      o_tx_ready = 1'b0;
   end
   // A slow master drops ready two cycles out of four.
   always @(negedge i_core_clk) begin
      cyc <= cyc + 1;
      o_bit_tick <= (cyc % P_TICK) == 0;
      o_tx_ready <= !i_slow || cyc[1];
   end
   always @(posedge i_core_clk) begin
      if (i_tx.valid && first_tx < 0) first_tx = cyc;
      if (i_tx.valid && o_tx_ready) rsp.push_back(i_tx.data);
   end
   // ***************************************************************
   // Frame tasks
   // ***************************************************************
   task automatic quiet(input int ticks);
      repeat (ticks * P_TICK) @(negedge i_core_clk);
   endtask
   // Idle data shows the inverse of the last byte, never a stale copy.
   task automatic send(input logic [7:0] q[$]);
      first_tx = -1;
      foreach (q[i]) begin
         repeat (3 * P_TICK) @(negedge i_core_clk);
         o_rx = {1'b1, q[i]};
         @(negedge i_core_clk);
         o_rx = {1'b0, ~q[i]};
      end
      last_rx = cyc;
   endtask
endmodule

// ### test/tb_mbrtu_slave.sv
// Self-checking bench for the Modbus-RTU slave frame handler.
`timescale 1ns/1ps
module tb_mbrtu_slave;
   // ***************************************************************
   // Signals and instances
   // ***************************************************************
   typedef logic [7:0] mbrtu_q_t[$];
   localparam int T = 4;
   localparam int P = 4;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic slow = 1'b0;
   logic lock = 1'b0;
   logic [5:0] node = 6'h20;
   logic [9:0] wt = 10'h000;
   logic bit_tick;
   logic tx_ready;
   mbrtu_pkg::mbrtu_byte_t rx;
   mbrtu_pkg::mbrtu_byte_t tx;
   logic [31:0] coils;
   logic [15:0][15:0] regs;
   logic [31:0] coils_m = 32'h00000000;
   logic [15:0] regs_m[16];
   logic [15:0] seed = 16'hF9B9;
   logic [7:0] xc[7] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h21, 8'h22, 8'h03};
   wire [7:0] nd = {2'b00, node};
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   mbrtu_slave #(.P_CYC_PER_MS(P)) mbrtu_slave_i (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_bit_tick(bit_tick), .i_rx(rx),
      .i_tx_ready(tx_ready), .o_tx(tx), .i_node_address_setting(node),
      .i_response_wait_time(wt), .i_write_lock(lock), .o_coils(coils), .o_hold_regs(regs));
   mbrtu_master_model #(.P_TICK(T)) mbrtu_master_model_i (
      .i_core_clk(i_core_clk), .i_slow(slow), .i_tx(tx), .o_bit_tick(bit_tick),
      .o_rx(rx), .o_tx_ready(tx_ready));
   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic tally_and_finish();
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function automatic mbrtu_q_t with_crc(mbrtu_q_t q, bit good);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      c = good ? c : ~c;
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      return q;
   endfunction
   // Mode 1 uses the longest wait, mode 2 adds a stray byte during it.
   task automatic run(mbrtu_q_t q, mbrtu_q_t e, int mode = 0, bit good = 1, int pre = 26);
      logic [15:0] r;
      int n;
      int lo;
      int hi;
      r = rnd();
      wt = (mode != 0) ? 10'h3E8 : {8'h00, r[1:0]};
      slow = r[2];
      mbrtu_master_model_i.quiet(pre);
      chk(mbrtu_master_model_i.rsp.size(), 0);
      mbrtu_master_model_i.send(with_crc(q, good));
      if (mode == 2) begin
         mbrtu_master_model_i.quiet(30);
         mbrtu_master_model_i.send('{8'h55});
      end
      if (e.size() != 0) e = with_crc(e, 1'b1);
      lo = 23 * T + wt * P;
      hi = 26 * T + wt * (P + 1) + 16;
      n = 0;
      while (n < hi + 200 && (e.size() == 0 || mbrtu_master_model_i.rsp.size() < e.size())) begin
         @(negedge i_core_clk);
         n++;
      end
      chk(mbrtu_master_model_i.rsp.size(), e.size());
      foreach (mbrtu_master_model_i.rsp[i]) begin
         if (i < e.size()) chk(mbrtu_master_model_i.rsp[i], e[i]);
      end
      if (e.size() != 0) begin
         n = mbrtu_master_model_i.first_tx - mbrtu_master_model_i.last_rx;
         chk(n >= lo && n <= hi, 1);
      end
      @(negedge i_core_clk);
      mbrtu_master_model_i.rsp.delete();
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   initial begin
      mbrtu_q_t q;
      mbrtu_q_t e;
      mbrtu_q_t none;
      logic [15:0] v;
      logic [15:0] r;
      logic [7:0] a;
      foreach (regs_m[i]) regs_m[i] = 16'h0000;
      repeat (10) @(negedge i_core_clk);
      i_rst = 1'b0;
      chk({23'h0, tx}, 32'h0);
      for (int k = 0; k < 6; k++) begin
         v = rnd();
         a = (k == 0) ? 8'h0F : {4'h0, v[11:8]};
         v = (k == 0) ? 16'h7FFF : (rnd() & 16'h7FFF);
         q = '{nd, 8'h06, 8'h00, a, v[15:8], v[7:0]};
         run(q, q);
         regs_m[a[3:0]] = v;
      end
      q = '{nd, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h04, 8'h08};
      for (int k = 12; k < 16; k++) begin
         v = rnd() & 16'h7FFF;
         regs_m[k] = v;
         q.push_back(v[15:8]);
         q.push_back(v[7:0]);
      end
      run(q, q);
      q = '{nd, 8'h03, 8'h00, 8'h0C, 8'h00, 8'h04};
      e = '{nd, 8'h03, 8'h08};
      for (int k = 12; k < 16; k++) begin
         e.push_back(regs_m[k][15:8]);
         e.push_back(regs_m[k][7:0]);
      end
      run(q, e);
      v = rnd();
      r = rnd();
      q = '{nd, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h20, 8'h04, v[7:0], v[15:8], r[7:0], r[15:8]};
      run(q, q);
      coils_m = {r, v};
      v = rnd();
      a = {3'h0, v[4:0]};
      q = '{nd, 8'h05, 8'h00, a, v[5] ? 8'hFF : 8'h00, 8'h00};
      run(q, q);
      coils_m[a[4:0]] = v[5];
      v = coils_m[18:3] & 16'h1FFF;
      q = '{nd, 8'h01, 8'h00, 8'h03, 8'h00, 8'h0D};
      e = '{nd, 8'h01, 8'h02, v[7:0], v[15:8]};
      run(q, e);
      v = rnd();
      q = '{nd, 8'h08, v[7:0], v[15:8], 8'h00};
      run(q, q, 1);
      run(q, none, 0, 1, 0);
      v = rnd();
      node = {1'b0, v[4:0]} + 6'h01;
      // The address net follows the new setting only once this process yields.
      @(negedge i_core_clk);
      for (int k = 0; k < 7; k++) begin
         lock = (k == 5);
         case (k)
            0: q = '{nd, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
            1: q = '{nd, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05};
            2: q = '{nd, 8'h01, 8'h00, 8'h00, 8'h00, 8'h21};
            3: q = '{nd, 8'h06, 8'h00, 8'h10, 8'h00, 8'h01};
            4: q = '{nd, 8'h06, 8'h00, 8'h01, 8'h80, 8'h00};
            6: q = '{nd, 8'h05, 8'h00, 8'h01, 8'h12, 8'h34};
            default: q = '{nd, 8'h06, 8'h00, 8'h01, 8'h00, 8'h01};
         endcase
         e = '{nd, q[1] | 8'h80, xc[k]};
         run(q, e);
      end
      lock = 1'b0;
      for (int k = 0; k < 6; k++) begin
         v = rnd() & 16'h7FFF;
         q = '{nd, 8'h06, 8'h00, 8'h02, v[15:8], v[7:0]};
         if (k == 0) q[0] = 8'h00;
         if (k == 1) q = '{8'h00, 8'h08, 8'h12};
         if (k == 2) q[0] = {2'b00, node + 6'h01};
         if (k == 4) q.push_back(8'h00);
         if (k == 5) q = '{nd, 8'h08, 8'h34};
         run(q, none, (k == 5) ? 2 : 0, k != 3);
         if (k == 3) run(q, q);
         if (k == 0 || k == 3) regs_m[2] = v;
      end
      chk(coils, coils_m);
      for (int k = 0; k < 16; k++) chk(regs[k], regs_m[k]);
      tally_and_finish();
   end
endmodule
